// ===== inc/dpcr_map.svh
// offsets, field positions and counts for pin configuration and routing
`ifndef DPCR_MAP_SVH
`define DPCR_MAP_SVH

`define DPCR_TB_FREQ_HZ   20000000
`define DPCR_CORE_FREQ_HZ 50000000
`define DPCR_NUM_PORTS    4
`define DPCR_PORT_W       8
`define DPCR_DATA_W       32
`define DPCR_NUM_GROUPS   2
`define DPCR_NUM_LINES    7
`define DPCR_CLK_LINE     7
`define DPCR_CTL_PER_GRP  4
`define DPCR_NCTL         8
`define DPCR_CTL_REQ      0
`define DPCR_CTL_ACK      1
`define DPCR_CTL_STOP     2
`define DPCR_CTL_PCLK     3
`define DPCR_GP_ACK       0
`define DPCR_GP_PCLK      1

`endif

// ===== inc/dpcr_pkg.sv
// types shared by the pin configuration and routing block
package dpcr_pkg;

  typedef enum logic [1:0] {
    PM_INPUT = 2'h0,
    PM_STD   = 2'h1,
    PM_WOR   = 2'h2
  } dpcr_pin_mode_e;

  typedef enum logic [1:0] {
    GM_UNSTROBED = 2'h0,
    GM_PATGEN    = 2'h1,
    GM_HANDSHAKE = 2'h2
  } dpcr_grp_mode_e;

  // pin values offered by a group's sequencer
  typedef struct packed {
    logic req;
    logic req_oe;
    logic ack;
    logic pclk;
    logic pclk_oe;
  } dpcr_grp_drv_s;

  // sampled control inputs of a group
  typedef struct packed {
    logic req;
    logic group_start_trigger;
    logic group_stop_trigger;
    logic pclk;
  } dpcr_grp_sense_s;

endpackage : dpcr_pkg

// ===== src/dpcr_port_drv.sv
// driver and sampler for one eight-bit data port
`timescale 1ns/1ps
`default_nettype none
`include "dpcr_map.svh"

module dpcr_port_drv
  import dpcr_pkg::*;
#(
  parameter int W = `DPCR_PORT_W
) (
  input  wire logic            core_clk_in,
  input  wire logic            arst_n_in,
  input  wire logic            ce_in,
  input  wire logic            drv_rst_in,
  input  wire logic [W-1:0][1:0] mode_in,
  input  wire logic            strobed_in,
  input  wire logic            stb_out_in,
  input  wire logic [W-1:0]    uns_data_in,
  input  wire logic [W-1:0]    stb_data_in,
  input  wire logic [W-1:0]    pin_in,
  output logic      [W-1:0]    pin_out,
  output logic      [W-1:0]    pin_oe_out,
  output logic      [W-1:0]    level_out
);

  logic [W-1:0] out_next;
  logic [W-1:0] oe_next;

  always_comb begin
    out_next = '0;
    oe_next  = '0;
    if (strobed_in) begin
      // whole port, standard drivers only
      oe_next  = {W{stb_out_in}};
      out_next = stb_data_in;
    end else begin
      for (int i = 0; i < W; i++) begin
        case (dpcr_pin_mode_e'(mode_in[i]))
          PM_STD: begin
            oe_next[i]  = 1'b1;
            out_next[i] = uns_data_in[i];
          end
          PM_WOR: begin
            oe_next[i]  = ~uns_data_in[i];
            out_next[i] = 1'b0;
          end
          default: begin
            oe_next[i]  = 1'b0;
            out_next[i] = 1'b0;
          end
        endcase
      end
    end
    if (drv_rst_in) begin
      oe_next  = '0;
      out_next = '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_out    <= '0;
      pin_oe_out <= '0;
      level_out  <= '0;
    end else if (ce_in) begin
      pin_out    <= out_next;
      pin_oe_out <= oe_next;
      // true pin level, so a wired-OR line pulled low elsewhere shows
      level_out  <= pin_in;
    end
  end

endmodule : dpcr_port_drv
`default_nettype wire

// ===== src/dpcr_top.sv
// timebase select, trigger line routing and data pin configuration
`timescale 1ns/1ps
`default_nettype none
`include "dpcr_map.svh"

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - one 20 MHz timebase feeds handshake logic and pattern intervals
// - software picks internal timebase or the one on the bus clock line
// - with internal timebase, optionally drive it onto the bus clock line
// - after reset use internal timebase and leave bus clock line undriven
// - backplane variant uses trigger line 7 as the bus clock line
// - any control signal may drive or receive any of seven trigger lines
// - trigger lines 0 to 6 map straight to backplane lines 0 to 6
// - four eight-bit data ports numbered 0 to 3
// - unstrobed pins each set as input, standard or wired-OR output
// - standard output drives both levels regardless of pull bias
// - wired-OR output drives low for zero and floats for one
// - actual level of a wired-OR pin can be read back
// - strobed direction is set per whole port only
// - a port joins strobed transfers only once assigned to a group
// - strobed outputs always use standard drivers, never wired-OR
// - two independent handshaking groups with their own control pins
// - pattern mode uses request, start, stop; handshake request, ack, clock
// - all data and control drivers float at power-up and driver reset
// - idle group: request, stop are inputs; ack, clock are outputs
// - grouped ports: first port is low byte, fourth port high byte
module dpcr_top
  import dpcr_pkg::*;
(
  input  wire logic                          core_clk_in,
  input  wire logic                          arst_n_in,
  input  wire logic                          ce_in,
  input  wire logic                          drv_rst_in,
  input  wire logic                          tb_import_in,
  input  wire logic                          tb_export_in,
  input  wire logic                          int_tb_in,
  output logic                               tb_out,
  output logic                               tb_imported_out,
  input  wire logic [`DPCR_CLK_LINE:0]       bus_in,
  output logic      [`DPCR_CLK_LINE:0]       bus_out,
  output logic      [`DPCR_CLK_LINE:0]       bus_oe_out,
  input  wire logic [`DPCR_NUM_LINES-1:0]    line_drv_en_in,
  input  wire logic [`DPCR_NUM_LINES-1:0][2:0] line_src_in,
  input  wire logic [`DPCR_NCTL-1:0]         ctl_rx_en_in,
  input  wire logic [`DPCR_NCTL-1:0][2:0]    ctl_rx_sel_in,
  input  wire logic [`DPCR_NCTL-1:0]         ctl_pin_in,
  output logic      [`DPCR_NCTL-1:0]         ctl_pin_out,
  output logic      [`DPCR_NCTL-1:0]         ctl_oe_out,
  input  wire dpcr_grp_mode_e                grp_mode_in [2],
  input  wire logic [1:0]                    grp_dir_out_in,
  input  wire dpcr_grp_drv_s                 grp_drv_in [2],
  input  wire logic [1:0][1:0]               gp_out_in,
  output dpcr_grp_sense_s                    grp_sense_out [2],
  input  wire logic [`DPCR_DATA_W-1:0][1:0]  pin_mode_in,
  input  wire logic [3:0]                    port_assign_in,
  input  wire logic [3:0]                    port_grp_in,
  input  wire logic [`DPCR_DATA_W-1:0]       uns_data_in,
  input  wire logic [1:0][`DPCR_DATA_W-1:0]  grp_wdata_in,
  output logic      [1:0][`DPCR_DATA_W-1:0]  grp_rdata_out,
  output logic      [`DPCR_DATA_W-1:0]       pin_level_out,
  input  wire logic [7:0]                    port_zero_lines_in,
  output logic      [7:0]                    port_zero_lines_out,
  output logic      [7:0]                    port_zero_lines_oe_out,
  input  wire logic [7:0]                    port_one_lines_in,
  output logic      [7:0]                    port_one_lines_out,
  output logic      [7:0]                    port_one_lines_oe_out,
  input  wire logic [7:0]                    port_two_lines_in,
  output logic      [7:0]                    port_two_lines_out,
  output logic      [7:0]                    port_two_lines_oe_out,
  input  wire logic [7:0]                    port_three_lines_in,
  output logic      [7:0]                    port_three_lines_out,
  output logic      [7:0]                    port_three_lines_oe_out
);

  localparam int CLKL = `DPCR_CLK_LINE;
  localparam int NLN  = `DPCR_NUM_LINES;
  localparam int CPG  = `DPCR_CTL_PER_GRP;

  // byte lane of port p inside its group word: count lower ports
  // sharing the group, so the lowest-numbered port lands in the low byte
  function automatic logic [1:0] slot_of(input int        p,
                                         input logic [3:0] asg,
                                         input logic [3:0] grp);
    logic [1:0] n;
    n = 2'h0;
    for (int q = 0; q < `DPCR_NUM_PORTS; q++) begin
      if (q < p && asg[q] && grp[q] == grp[p]) begin
        n = n + 2'h1;
      end
    end
    return n;
  endfunction : slot_of

  ////////////////////////////////////////////////////////////////////////////
  // data ports

  logic [3:0][7:0] pin_in_w;
  logic [3:0][7:0] pin_out_w;
  logic [3:0][7:0] pin_oe_w;
  logic [3:0][7:0] pin_lvl_w;
  logic [3:0][1:0] slot_w;

  // port numbers 0 to 3 in order
  assign pin_in_w = {port_three_lines_in, port_two_lines_in,
                     port_one_lines_in, port_zero_lines_in};

  for (genvar p = 0; p < `DPCR_NUM_PORTS; p++) begin : g_port
    logic g_w;
    logic stb_w;
    assign g_w    = port_grp_in[p];
    assign slot_w[p] = slot_of(p, port_assign_in, port_grp_in);
    // assigned but idle group leaves the port an input
    assign stb_w  = grp_dir_out_in[g_w] &&
                    (grp_mode_in[g_w] != GM_UNSTROBED);
    dpcr_port_drv #(.W(`DPCR_PORT_W)) u_drv (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .ce_in       (ce_in),
      .drv_rst_in  (drv_rst_in),
      .mode_in     (pin_mode_in[p*8 +: 8]),
      .strobed_in  (port_assign_in[p]),
      .stb_out_in  (stb_w),
      .uns_data_in (uns_data_in[p*8 +: 8]),
      .stb_data_in (grp_wdata_in[g_w][slot_w[p]*8 +: 8]),
      .pin_in      (pin_in_w[p]),
      .pin_out     (pin_out_w[p]),
      .pin_oe_out  (pin_oe_w[p]),
      .level_out   (pin_lvl_w[p])
    );
  end

  assign port_zero_lines_out      = pin_out_w[0];
  assign port_zero_lines_oe_out   = pin_oe_w[0];
  assign port_one_lines_out       = pin_out_w[1];
  assign port_one_lines_oe_out    = pin_oe_w[1];
  assign port_two_lines_out       = pin_out_w[2];
  assign port_two_lines_oe_out    = pin_oe_w[2];
  assign port_three_lines_out     = pin_out_w[3];
  assign port_three_lines_oe_out  = pin_oe_w[3];
  assign pin_level_out            = pin_lvl_w;

  ////////////////////////////////////////////////////////////////////////////
  // control pins, trigger lines and timebase

  logic [1:0][`DPCR_DATA_W-1:0] rdata_next;
  logic [`DPCR_NCTL-1:0]        ctl_out_next;
  logic [`DPCR_NCTL-1:0]        ctl_oe_next;
  logic [`DPCR_NCTL-1:0]        rx_w;
  logic [CLKL:0]                bus_out_next;
  logic [CLKL:0]                bus_oe_next;
  dpcr_grp_sense_s              sense_next [2];
  logic                         tb_src_w;

  // line 7 carries the timebase; a select of 7 means no routing
  always_comb begin
    for (int j = 0; j < `DPCR_NCTL; j++) begin
      if (ctl_rx_en_in[j] && int'(ctl_rx_sel_in[j]) < NLN) begin
        rx_w[j] = bus_in[ctl_rx_sel_in[j]];
      end else begin
        rx_w[j] = ctl_pin_in[j];
      end
    end
  end

  always_comb begin
    ctl_out_next = '0;
    ctl_oe_next  = '0;
    rdata_next   = '0;
    for (int g = 0; g < `DPCR_NUM_GROUPS; g++) begin
      case (grp_mode_in[g])
        GM_UNSTROBED: begin
          // spare outputs on ack and clock pins
          ctl_oe_next[g*CPG+`DPCR_CTL_ACK]  = 1'b1;
          ctl_out_next[g*CPG+`DPCR_CTL_ACK] = gp_out_in[g][`DPCR_GP_ACK];
          ctl_oe_next[g*CPG+`DPCR_CTL_PCLK] = 1'b1;
          ctl_out_next[g*CPG+`DPCR_CTL_PCLK] =
            gp_out_in[g][`DPCR_GP_PCLK];
        end
        GM_PATGEN: begin
          // request may go either way; start and stop are inputs
          ctl_oe_next[g*CPG+`DPCR_CTL_REQ] = grp_drv_in[g].req_oe;
          ctl_out_next[g*CPG+`DPCR_CTL_REQ] = grp_drv_in[g].req;
        end
        GM_HANDSHAKE: begin
          ctl_oe_next[g*CPG+`DPCR_CTL_ACK]   = 1'b1;
          ctl_out_next[g*CPG+`DPCR_CTL_ACK]  = grp_drv_in[g].ack;
          ctl_oe_next[g*CPG+`DPCR_CTL_PCLK]  = grp_drv_in[g].pclk_oe;
          ctl_out_next[g*CPG+`DPCR_CTL_PCLK] = grp_drv_in[g].pclk;
        end
        default: begin
          ctl_oe_next[g*CPG+`DPCR_CTL_ACK] = 1'b0;
        end
      endcase
      sense_next[g].req                 = rx_w[g*CPG+`DPCR_CTL_REQ];
      sense_next[g].group_start_trigger = rx_w[g*CPG+`DPCR_CTL_ACK];
      sense_next[g].group_stop_trigger  = rx_w[g*CPG+`DPCR_CTL_STOP];
      sense_next[g].pclk                = rx_w[g*CPG+`DPCR_CTL_PCLK];
    end
    // group word assembly from the sampled port levels
    for (int p = 0; p < `DPCR_NUM_PORTS; p++) begin
      if (port_assign_in[p]) begin
        rdata_next[port_grp_in[p]][slot_w[p]*8 +: 8] =
          pin_lvl_w[p];
      end
    end
    if (drv_rst_in) begin
      ctl_oe_next = '0;
    end
  end

  assign tb_src_w = tb_import_in ? bus_in[CLKL] : int_tb_in;

  always_comb begin
    bus_out_next = '0;
    bus_oe_next  = '0;
    // only output-direction signals reach a line
    for (int i = 0; i < NLN; i++) begin
      if (line_drv_en_in[i] && ctl_oe_next[line_src_in[i]]) begin
        bus_oe_next[i]  = 1'b1;
        bus_out_next[i] = ctl_out_next[line_src_in[i]];
      end
    end
    // export is refused while importing from the same line
    bus_oe_next[CLKL]  = tb_export_in && !tb_import_in;
    bus_out_next[CLKL] = int_tb_in;
    if (drv_rst_in) begin
      bus_oe_next = '0;
    end
  end

  // the timebase is sampled by the core clock, so downstream logic
  // sees its edges with up to one core period of jitter
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tb_out          <= 1'b0;
      tb_imported_out <= 1'b0;
      bus_out         <= '0;
      bus_oe_out      <= '0;
      ctl_pin_out     <= '0;
      ctl_oe_out      <= '0;
      grp_rdata_out   <= '0;
      grp_sense_out   <= '{default: '0};
    end else if (ce_in) begin
      tb_out          <= tb_src_w;
      tb_imported_out <= tb_import_in;
      bus_out         <= bus_out_next;
      bus_oe_out      <= bus_oe_next;
      ctl_pin_out     <= ctl_out_next;
      ctl_oe_out      <= ctl_oe_next;
      grp_rdata_out   <= rdata_next;
      grp_sense_out   <= sense_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  logic live_w;
  assign live_w = ce_in && !drv_rst_in;

  a_drv_rst_hiz: assert property (
    ce_in && drv_rst_in |=> ctl_oe_out == '0 && bus_oe_out == '0 &&
      pin_oe_w == '0)
    else $error("drivers not released by driver reset");

  a_import_quiet: assert property (
    tb_imported_out |-> !bus_oe_out[CLKL])
    else $error("bus clock line driven while importing");

  a_tb_follow: assert property (
    ce_in |=> tb_out == $past(tb_src_w))
    else $error("timebase does not follow selected source");

  a_tb_export: assert property (
    live_w && tb_export_in && !tb_import_in |=>
      bus_oe_out[CLKL] && bus_out[CLKL] == $past(int_tb_in))
    else $error("internal timebase not exported");

  a_line_route: assert property (
    live_w && line_drv_en_in[0] && line_src_in[0] == 3'h1 &&
      grp_mode_in[0] == GM_UNSTROBED |=>
      bus_oe_out[0] && bus_out[0] == $past(gp_out_in[0][0]))
    else $error("control signal not routed to trigger line");

  a_std_drive: assert property (
    live_w && !port_assign_in[0] && pin_mode_in[0] == PM_STD |=>
      pin_oe_w[0][0] && pin_out_w[0][0] == $past(uns_data_in[0]))
    else $error("standard output not driven");

  a_wor_drive: assert property (
    live_w && !port_assign_in[0] && pin_mode_in[0] == PM_WOR |=>
      !pin_out_w[0][0] && pin_oe_w[0][0] == !$past(uns_data_in[0]))
    else $error("wired-OR output drives high");

  a_wor_readback: assert property (
    ce_in |=> pin_level_out[0] == $past(port_zero_lines_in[0]))
    else $error("pin level not read back");

  a_strobe_std: assert property (
    live_w && port_assign_in[0] && !port_grp_in[0] && grp_dir_out_in[0] &&
      grp_mode_in[0] != GM_UNSTROBED |=>
      pin_oe_w[0] == 8'hFF && pin_out_w[0] == $past(grp_wdata_in[0][7:0]))
    else $error("strobed port not on standard drivers at low byte");

  a_idle_override: assert property (
    live_w && port_assign_in[0] && !port_grp_in[0] &&
      grp_mode_in[0] == GM_UNSTROBED |=> pin_oe_w[0] == 8'h00)
    else $error("assigned port driven while group idle");

  a_idle_gp_dir: assert property (
    live_w && grp_mode_in[0] == GM_UNSTROBED |=>
      ctl_oe_out[1] && ctl_oe_out[3] && !ctl_oe_out[0] && !ctl_oe_out[2])
    else $error("idle group control directions wrong");

  a_hs_pin_dirs: assert property (
    live_w && grp_mode_in[0] == GM_HANDSHAKE |=>
      ctl_oe_out[1] && !ctl_oe_out[0] && !ctl_oe_out[2] &&
      ctl_pin_out[1] == $past(grp_drv_in[0].ack))
    else $error("handshake control directions wrong");

  a_line_receive: assert property (
    ce_in && ctl_rx_en_in[0] && ctl_rx_sel_in[0] != 3'h7 |=>
      grp_sense_out[0].req == $past(bus_in[ctl_rx_sel_in[0]]))
    else $error("control input not taken from trigger line");

  a_group_word: assert property (
    ce_in && port_assign_in[0] && !port_grp_in[0] |=>
      grp_rdata_out[0][7:0] == $past(pin_level_out[7:0]))
    else $error("first port not in low byte of group word");

  a_ce_freeze: assert property (
    !ce_in |=> $stable(ctl_oe_out) && $stable(bus_oe_out) &&
      $stable(pin_oe_w))
    else $error("driver state moved while clock enable low");

  c_import: cover property (ce_in && tb_import_in ##1 tb_imported_out);
  c_export: cover property (bus_oe_out[CLKL] ##1 !bus_oe_out[CLKL]);
  c_wor_low: cover property (
    port_zero_lines_oe_out[0] == 1'b0 && pin_level_out[0] == 1'b0);
  c_strobed: cover property (port_zero_lines_oe_out == 8'hFF);
  c_grouped: cover property (port_assign_in[0] && grp_rdata_out[0] != '0);

endmodule : dpcr_top
`default_nettype wire

// ===== tb/dpcr_far_model.sv
// far side: peripheral on the data and control pins, other boards on the bus
`timescale 1ns/1ps
`default_nettype none

module dpcr_far_model #(
  parameter int           N    = 40,
  parameter logic [N-1:0] PULL = '0
) (
  input  wire logic [N-1:0] dut_val_in,
  input  wire logic [N-1:0] dut_oe_in,
  input  wire logic [N-1:0] ext_val_in,
  input  wire logic [N-1:0] ext_oe_in,
  input  wire logic [7:0]   bus_val_in,
  input  wire logic [7:0]   bus_oe_in,
  input  wire logic [7:0]   brd_val_in,
  input  wire logic [7:0]   brd_oe_in,
  input  wire logic         brd_clk_en_in,
  output logic      [N-1:0] pin_out,
  output logic      [7:0]   bus_out
);
  logic       brd_clk = 1'b0;
  logic [7:0] bv;
  logic [7:0] bo;

  // other board's 20 MHz timebase, kept off the core clock edges
  initial begin
    #7;
    forever #25 brd_clk = ~brd_clk;
  end

  // any party may pull low; undriven lines settle to their bias
  assign pin_out = (~dut_oe_in | dut_val_in) & (~ext_oe_in | ext_val_in)
                 & (dut_oe_in | ext_oe_in | PULL);

  // bus lines are pulled up when nobody drives them
  always_comb begin
    bv = brd_val_in;
    bo = brd_oe_in;
    if (brd_clk_en_in) begin
      bv[7] = brd_clk;
      bo[7] = 1'b1;
    end
    bus_out = (~bus_oe_in | bus_val_in) & (~bo | bv);
  end
endmodule : dpcr_far_model
`default_nettype wire

// ===== tb/dpcr_top_tb.sv
// testbench for timebase select, trigger routing and pin configuration
`timescale 1ns/1ps
`default_nettype none

module dpcr_top_tb
  import dpcr_pkg::*;
;
  logic                  clk        = 1'b0;
  logic                  rst_n      = 1'b0;
  logic                  ce         = 1'b1;
  logic                  drv_rst    = 1'b0;
  logic                  imp        = 1'b0;
  logic                  exp_en     = 1'b1;
  logic                  int_tb     = 1'b0;
  logic                  brd_clk_en = 1'b0;
  logic                  tb_o;
  logic                  tb_imp_o;
  logic [7:0]            bus_i, bus_o, bus_oe, ctl_o, ctl_oe, c;
  logic [7:0]            brd_val    = '0;
  logic [7:0]            brd_oe     = '0;
  logic [7:0]            rx_en      = '0;
  logic [7:0][2:0]       rx_sel     = '1;
  logic [6:0]            line_en    = '0;
  logic [6:0]            e;
  logic [6:0][2:0]       line_src   = '0;
  logic [39:0]           pin_i;
  logic [39:0]           ext_val    = '0;
  logic [39:0]           ext_oe     = '0;
  logic [3:0][7:0]       p_o, p_oe;
  logic [31:0][1:0]      pin_mode   = {32{2'h1}};
  logic [31:0]           uns        = '0;
  logic [31:0]           level;
  logic [1:0][31:0]      wdata      = '0;
  logic [1:0][31:0]      rdata;
  logic [1:0][1:0]       gp_out     = '0;
  logic [1:0]            dir_out    = '0;
  logic [3:0]            p_asg      = '0;
  logic [3:0]            p_grp      = '0;
  dpcr_grp_mode_e        grp_mode [2];
  dpcr_grp_drv_s         grp_drv [2];
  dpcr_grp_sense_s       sense [2];
  int                    err_count  = 0;
  int                    tests_run  = 0;
  int                    a, b;

  always #10 clk = ~clk;

  // offset keeps the timebase edges away from both clock edges
  initial begin
    #3;
    forever #25 int_tb = ~int_tb;
  end

  dpcr_top i_dut (
    .core_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .drv_rst_in(drv_rst),
    .tb_import_in(imp), .tb_export_in(exp_en), .int_tb_in(int_tb),
    .tb_out(tb_o), .tb_imported_out(tb_imp_o), .bus_in(bus_i),
    .bus_out(bus_o), .bus_oe_out(bus_oe), .line_drv_en_in(line_en),
    .line_src_in(line_src), .ctl_rx_en_in(rx_en), .ctl_rx_sel_in(rx_sel),
    .ctl_pin_in(pin_i[39:32]), .ctl_pin_out(ctl_o), .ctl_oe_out(ctl_oe),
    .grp_mode_in(grp_mode), .grp_dir_out_in(dir_out),
    .grp_drv_in(grp_drv), .gp_out_in(gp_out), .grp_sense_out(sense),
    .pin_mode_in(pin_mode), .port_assign_in(p_asg), .port_grp_in(p_grp),
    .uns_data_in(uns), .grp_wdata_in(wdata), .grp_rdata_out(rdata),
    .pin_level_out(level), .port_zero_lines_in(pin_i[7:0]),
    .port_zero_lines_out(p_o[0]), .port_zero_lines_oe_out(p_oe[0]),
    .port_one_lines_in(pin_i[15:8]), .port_one_lines_out(p_o[1]),
    .port_one_lines_oe_out(p_oe[1]), .port_two_lines_in(pin_i[23:16]),
    .port_two_lines_out(p_o[2]), .port_two_lines_oe_out(p_oe[2]),
    .port_three_lines_in(pin_i[31:24]), .port_three_lines_out(p_o[3]),
    .port_three_lines_oe_out(p_oe[3])
  );

  // data lines pulled up for wired-OR use, control lines pulled down
  dpcr_far_model #(.N(40), .PULL({8'h00, 32'hFFFF_FFFF})) i_far (
    .dut_val_in({ctl_o, p_o}), .dut_oe_in({ctl_oe, p_oe}),
    .ext_val_in(ext_val), .ext_oe_in(ext_oe), .bus_val_in(bus_o),
    .bus_oe_in(bus_oe), .brd_val_in(brd_val), .brd_oe_in(brd_oe),
    .brd_clk_en_in(brd_clk_en), .pin_out(pin_i), .bus_out(bus_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : step

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // edges seen on timebase out and bus line 7 over 40 cycles
  task automatic togs(output int na, output int nb);
    logic pa, pb;
    na = 0;
    nb = 0;
    pa = tb_o;
    pb = bus_o[7];
    repeat (40) begin
      step(1);
      na += int'(tb_o !== pa);
      nb += int'(bus_o[7] !== pb);
      pa = tb_o;
      pb = bus_o[7];
    end
  endtask : togs

  function automatic logic [63:0] pins_exp();
    logic [31:0] oe, o;
    for (int i = 0; i < 32; i++) begin
      oe[i] = (pin_mode[i] == 2'h1) | (pin_mode[i] == 2'h2 & ~uns[i]);
      o[i] = oe[i] & (pin_mode[i] == 2'h1) & uns[i];
    end
    return {oe, o};
  endfunction : pins_exp

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin
    #50us;
    err_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    grp_mode[0] = GM_UNSTROBED;
    grp_mode[1] = GM_UNSTROBED;
    grp_drv[0] = '0;
    grp_drv[1] = '0;
    step(3);
    chk({p_oe, ctl_oe, bus_oe, tb_imp_o}, '0);
    step(2);
    rst_n = 1'b1;
    step(2);
    togs(a, b);
    chk({bus_oe[7], a > 20, b > 20, tb_imp_o}, 4'hE);
    imp = 1'b1;
    step(2);
    togs(a, b);
    chk({bus_oe[7], a, tb_o, tb_imp_o}, {1'b0, 32'd0, 2'b11});
    brd_clk_en = 1'b1;
    step(2);
    togs(a, b);
    chk({bus_oe[7], a > 20}, 2'b01);
    imp = 1'b0;
    exp_en = 1'b0;
    brd_clk_en = 1'b0;
    step(2);
    chk(bus_oe[7], 1'b0);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 32; i++) pin_mode[i] = 2'((i + r) % 4);
      uns = r[0] ? 32'h5A3C_F069 : 32'hA5C3_0F96;
      step(2);
      chk({p_oe, p_o & p_oe}, pins_exp());
    end
    pin_mode = {32{2'h2}};
    uns = 32'hFFFF_FDFF;
    ext_oe[5] = 1'b1;
    step(2);
    chk(level, 32'hFFFF_FDDF);
    ext_oe = '0;
    line_en = 7'h7F;
    for (int k = 0; k < 7; k++) line_src[k] = 3'(2 * (k % 4) + 1);
    for (int v = 0; v < 2; v++) begin
      gp_out = v[0] ? 4'h6 : 4'h9;
      step(2);
      for (int k = 0; k < 7; k++) e[k] = gp_out[(k % 4) / 2][k % 2];
      for (int j = 0; j < 4; j++) c[2*j+:2] = {gp_out[j/2][j%2], 1'b0};
      chk({bus_oe[6:0], bus_o[6:0], ctl_oe, ctl_o & ctl_oe},
          {7'h7F, e, 8'hAA, c});
    end
    line_en = '0;
    rx_en = 8'h01;
    brd_oe = 8'h7F;
    for (int k = 0; k < 7; k++) begin
      rx_sel[0] = 3'(k);
      brd_val = ~(8'h01 << k);
      step(2);
      chk(sense[0].req, 1'b0);
      brd_val = 8'h01 << k;
      step(2);
      chk(sense[0].req, 1'b1);
    end
    brd_oe = '0;
    rx_en = '0;
    grp_mode[0] = GM_PATGEN;
    grp_mode[1] = GM_HANDSHAKE;
    grp_drv[0] = 5'b11000;
    grp_drv[1] = 5'b00101;
    ext_oe[34:33] = 2'b11;
    ext_val[34:33] = 2'b11;
    step(2);
    chk({ctl_oe & 8'hF7, ctl_o & ctl_oe & 8'hF7,
         sense[0].group_start_trigger, sense[0].group_stop_trigger},
        {8'hA1, 8'h21, 2'b11});
    ext_oe = '0;
    ext_val = '0;
    grp_mode[0] = GM_HANDSHAKE;
    grp_mode[1] = GM_UNSTROBED;
    p_asg = 4'hE;
    p_grp = 4'h4;
    dir_out = 2'b11;
    wdata[0] = 32'h1234_3CA5;
    wdata[1] = 32'hFFFF_FFFF;
    uns = '1;
    step(2);
    chk({p_oe, p_o & p_oe},
        64'hFF00_FF00_3C00_A500);
    dir_out = 2'b00;
    ext_oe[31:0] = 32'hFF00_FF00;
    ext_val[31:0] = 32'hC300_5A00;
    step(3);
    chk({p_oe, rdata[0]}, 64'h0000_C35A);
    ext_oe = '0;
    dir_out = 2'b11;
    pin_mode = {32{2'h1}};
    line_en = 7'h7F;
    exp_en = 1'b1;
    step(2);
    drv_rst = 1'b1;
    step(1);
    chk({p_oe, ctl_oe, bus_oe}, '0);
    drv_rst = 1'b0;
    step(2);
    chk(p_oe, 32'hFF00_FFFF);
    p_asg = 4'hF;
    step(2);
    chk({p_oe, p_o & p_oe},
        64'hFF00_FFFF_3400_3CA5);
    ce = 1'b0;
    grp_mode[0] = GM_UNSTROBED;
    step(2);
    chk(p_oe, 32'hFF00_FFFF); // frozen while ce low
    ce = 1'b1;
    step(2);
    chk(p_oe, 32'h0000_0000);
    summarize();
  end
endmodule : dpcr_top_tb
`default_nettype wire
